// *** rtl/cefl_pkg.sv ***
// constants shared by the comparator edge-flag block
package cefl_pkg;
    // avalon slave geometry, byte addresses
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [3:0]  OFS_CLEAR     = 4'h8;
    localparam logic [3:0]  OFS_IRQ_EN    = 4'hc;
    // comparator_control field positions
    localparam int unsigned CTRL_EN_BIT   = 7;
    localparam int unsigned CTRL_RES_BIT  = 6;
    localparam int unsigned CTRL_RISE_BIT = 5;
    localparam int unsigned CTRL_FALL_BIT = 4;
    localparam int unsigned CTRL_PHYS_LSB = 2;
    localparam int unsigned CTRL_NHYS_LSB = 0;
    localparam int unsigned CTRL_W        = 8;
    localparam int unsigned HYST_W        = 2;
    // event bits of status, clear and enable registers
    localparam int unsigned EV_RISE       = 0;
    localparam int unsigned EV_FALL       = 1;
    localparam int unsigned EV_W          = 2;
    // hysteresis encodings
    localparam logic [1:0]  HYST_OFF      = 2'h0;
    localparam logic [1:0]  HYST_5MV      = 2'h1;
    localparam logic [1:0]  HYST_10MV     = 2'h2;
    localparam logic [1:0]  HYST_20MV     = 2'h3;
    // reset values
    localparam logic        EN_RST        = 1'h0;
    localparam logic [1:0]  HYST_RST      = HYST_OFF;
    localparam logic [1:0]  IRQ_EN_RST    = 2'h0;
    localparam logic        WAIT_RST      = 1'h1;
endpackage

// *** rtl/cefl_sync.sv ***
// three-stage synchroniser with agreement filter for the comparator output
`timescale 1ns/1ps
`default_nettype none
module cefl_sync
    import cefl_pkg::*;
(
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    // asynchronous level in, filtered level out
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire  agree = (s2_reg == s3_reg);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_reg    <= 1'h0;
            s2_reg    <= 1'h0;
            s3_reg    <= 1'h0;
            level_reg <= 1'h0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign o_level = level_reg;

    property p_sync_agree;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s2_reg == s3_reg) |=> (level_reg == $past(s3_reg));
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("filtered level did not follow agreeing stages");

    property p_sync_hold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (s2_reg != s3_reg) |=> $stable(level_reg);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("filtered level moved while stages disagreed");
endmodule
`default_nettype wire

// *** rtl/cefl_edge_flag.sv ***
// edge detector with a sticky flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module cefl_edge_flag
    import cefl_pkg::*;
#(
    parameter logic RISE = 1'h1
)(
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    // level, arming and software clear
    input  wire logic i_level,
    input  wire logic i_arm,
    input  wire logic i_clr,
    // sticky flag and its next value
    output logic      o_flag,
    output logic      o_flag_next
);
    logic prev_reg;
    logic flag_reg;
    // prev tracks even when disarmed, so enabling never fakes an edge
    wire  set = i_arm && (i_level == RISE) && (prev_reg != i_level);

    assign o_flag_next = set | (flag_reg & ~i_clr);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_reg <= 1'h0;
            flag_reg <= 1'h0;
        end else begin
            prev_reg <= i_level;
            flag_reg <= o_flag_next;
        end
    end

    assign o_flag = flag_reg;

    property p_flag_set;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_arm && i_level == RISE && prev_reg != RISE) |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("edge did not set flag");

    property p_flag_sticky;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (flag_reg && !i_clr) |=> flag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without clear");

    property p_flag_clear;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_clr && !set) |=> !flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("clear did not reset flag");

    property p_flag_spurious;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!flag_reg && !(i_level == RISE && prev_reg != RISE)) |=> !flag_reg;
    endproperty
    a_flag_spurious: assert property (p_flag_spurious)
        else $error("flag set without matching edge");

    property p_set_wins;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (set && i_clr) |=> flag_reg;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a same-cycle edge");
endmodule
`default_nettype wire

// *** rtl/cefl_top.sv ***
// comparator control and edge-flag logic with avalon-mm register slave
//
// Overview of operation
// - result bit reads comparator state, read only
// - control bit 7 enables the comparator
// - rising edge sets sticky flag bit 5
// - falling edge sets sticky flag bit 4
// - bits 3-2 select positive hysteresis to core
// - bits 1-0 select negative hysteresis to core
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cefl_top
    import cefl_pkg::*;
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rstn,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [3:0]        i_byteenable,
    input  wire logic [DATA_W-1:0] i_writedata,
    output logic      [DATA_W-1:0] o_readdata,
    output logic                   o_waitrequest,
    // analog core
    input  wire logic              i_cmp_out,
    output logic                   o_cmp_enable,
    output logic      [HYST_W-1:0] o_cmp_pos_hyst_sel,
    output logic      [HYST_W-1:0] o_cmp_neg_hyst_sel,
    // interrupt
    output logic                   o_irq
);
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // registers
    logic              wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic              en_reg;
    logic [HYST_W-1:0] phys_reg;
    logic [HYST_W-1:0] nhys_reg;
    logic [EV_W-1:0]   ien_reg;
    logic              irq_reg;

    // comparator path
    logic              level;
    logic [EV_W-1:0]   flags;
    logic [EV_W-1:0]   flags_next;
    logic [EV_W-1:0]   flag_clr;

    // address decode
    wire sel_ctrl   = addr_hit(i_address, OFS_CTRL);
    wire sel_status = addr_hit(i_address, OFS_STATUS);
    wire sel_clear  = addr_hit(i_address, OFS_CLEAR);
    wire sel_ien    = addr_hit(i_address, OFS_IRQ_EN);

    // request phases: latch on first edge, complete on second
    wire req        = i_read | i_write;
    wire req_first  = req & wait_reg;
    wire wr_fire    = i_write & ~wait_reg & i_byteenable[0];
    wire ctrl_wr    = wr_fire & sel_ctrl;
    wire clear_wr   = wr_fire & sel_clear;
    wire ien_wr     = wr_fire & sel_ien;

    // comparator result reads low while disabled
    wire cmp_result = en_reg & level;

    // writing 0 to a flag bit of control clears it, as does a 1 to clear
    assign flag_clr[EV_RISE] = (ctrl_wr & ~i_writedata[CTRL_RISE_BIT])
                             | (clear_wr & i_writedata[EV_RISE]);
    assign flag_clr[EV_FALL] = (ctrl_wr & ~i_writedata[CTRL_FALL_BIT])
                             | (clear_wr & i_writedata[EV_FALL]);

    wire [CTRL_W-1:0] ctrl_view = {en_reg, cmp_result, flags[EV_RISE],
                                   flags[EV_FALL], phys_reg, nhys_reg};
    wire [DATA_W-1:0] rdata_next =
        sel_ctrl   ? DATA_W'(ctrl_view) :
        sel_status ? DATA_W'(flags)     :
        sel_ien    ? DATA_W'(ien_reg)   :
        {DATA_W{1'b0}};

    wire irq_next = |(flags_next & ien_reg);

    cefl_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (i_cmp_out),
        .o_level    (level)
    );

    genvar g;
    generate
        for (g = 0; g < EV_W; g++) begin : g_edge
            cefl_edge_flag #(
                .RISE (g == EV_RISE)
            ) u_flag (
                .i_core_clk  (i_core_clk),
                .i_rstn      (i_rstn),
                .i_level     (level),
                .i_arm       (en_reg),
                .i_clr       (flag_clr[g]),
                .o_flag      (flags[g]),
                .o_flag_next (flags_next[g])
            );
        end
    endgenerate

    // bus handshake
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_reg  <= WAIT_RST;
            rdata_reg <= {DATA_W{1'b0}};
        end else begin
            wait_reg <= ~req_first;
            if (req_first && i_read) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // control fields
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en_reg   <= EN_RST;
            phys_reg <= HYST_RST;
            nhys_reg <= HYST_RST;
        end else if (ctrl_wr) begin
            en_reg   <= i_writedata[CTRL_EN_BIT];
            phys_reg <= i_writedata[CTRL_PHYS_LSB +: HYST_W];
            nhys_reg <= i_writedata[CTRL_NHYS_LSB +: HYST_W];
        end
    end

    // interrupt enable and output
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ien_reg <= IRQ_EN_RST;
            irq_reg <= 1'h0;
        end else begin
            if (ien_wr) begin
                ien_reg <= i_writedata[EV_W-1:0];
            end
            irq_reg <= irq_next;
        end
    end

    assign o_readdata         = rdata_reg;
    assign o_waitrequest      = wait_reg;
    assign o_cmp_enable       = en_reg;
    assign o_cmp_pos_hyst_sel = phys_reg;
    assign o_cmp_neg_hyst_sel = nhys_reg;
    assign o_irq              = irq_reg;

    property p_result_read;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_read && !o_waitrequest && sel_ctrl)
            |-> (o_readdata[CTRL_RES_BIT] == $past(cmp_result));
    endproperty
    a_result_read: assert property (p_result_read)
        else $error("result bit does not show comparator state");

    property p_result_off;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!o_cmp_enable && i_read && o_waitrequest && sel_ctrl)
            |=> (o_readdata[CTRL_RES_BIT] == 1'b0);
    endproperty
    a_result_off: assert property (p_result_off)
        else $error("result bit high while comparator disabled");

    property p_enable_write;
        @(posedge i_core_clk) disable iff (!i_rstn)
        ctrl_wr |=> (o_cmp_enable == $past(i_writedata[CTRL_EN_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit not taken from control write");

    property p_flags_read;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_read && o_waitrequest && sel_ctrl)
            |=> (o_readdata[CTRL_RISE_BIT] == $past(flags[EV_RISE]))
             && (o_readdata[CTRL_FALL_BIT] == $past(flags[EV_FALL]));
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flag bits not shown in control read");

    property p_pos_hyst;
        @(posedge i_core_clk) disable iff (!i_rstn)
        ctrl_wr |=> (o_cmp_pos_hyst_sel == $past(i_writedata[3:2]));
    endproperty
    a_pos_hyst: assert property (p_pos_hyst)
        else $error("positive hysteresis not taken from bits 3-2");

    property p_neg_hyst;
        @(posedge i_core_clk) disable iff (!i_rstn)
        ctrl_wr |=> (o_cmp_neg_hyst_sel == $past(i_writedata[1:0]));
    endproperty
    a_neg_hyst: assert property (p_neg_hyst)
        else $error("negative hysteresis not taken from bits 1-0");

    property p_hyst_hold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !ctrl_wr |=> $stable(o_cmp_pos_hyst_sel) && $stable(o_cmp_neg_hyst_sel);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold)
        else $error("hysteresis changed without control write");

    property p_bus_answer;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (req && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest did not drop for exactly one cycle");

    property p_irq_level;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (|(flags & ien_reg)) && $stable(ien_reg) |-> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled flag set but interrupt low");

    // read-back views, latched on the first request edge
    property p_status_read;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_read && o_waitrequest && sel_status)
            |=> (o_readdata == {{(DATA_W-EV_W){1'b0}}, $past(flags)});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show the flags");

    property p_ctrl_fields;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_read && o_waitrequest && sel_ctrl)
            |=> (o_readdata[CTRL_EN_BIT] == $past(en_reg))
             && (o_readdata[CTRL_PHYS_LSB +: HYST_W] == $past(phys_reg))
             && (o_readdata[CTRL_NHYS_LSB +: HYST_W] == $past(nhys_reg))
             && (o_readdata[DATA_W-1:CTRL_W] == {(DATA_W-CTRL_W){1'b0}});
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("control read does not show the stored fields");

    // clear is write-only and holes read zero, so software sees no stale data
    property p_hole_read;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_read && o_waitrequest && !(sel_ctrl || sel_status || sel_ien))
            |=> (o_readdata == {DATA_W{1'b0}});
    endproperty
    a_hole_read: assert property (p_hole_read)
        else $error("clear or unmapped address read nonzero");

    property p_ien_write;
        @(posedge i_core_clk) disable iff (!i_rstn)
        ien_wr |=> (ien_reg == $past(i_writedata[EV_W-1:0]));
    endproperty
    a_ien_write: assert property (p_ien_write)
        else $error("interrupt enable not taken from write");

    property p_ien_hold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !ien_wr |=> $stable(ien_reg);
    endproperty
    a_ien_hold: assert property (p_ien_hold)
        else $error("interrupt enable changed without write");

    property p_enable_hold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !ctrl_wr |=> $stable(o_cmp_enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("enable changed without control write");

    // an edge seen while disabled must leave no trace
    property p_rise_needs_enable;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!o_cmp_enable && !flags[EV_RISE]) |=> !flags[EV_RISE];
    endproperty
    a_rise_needs_enable: assert property (p_rise_needs_enable)
        else $error("rise flag set while comparator disabled");

    property p_fall_needs_enable;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!o_cmp_enable && !flags[EV_FALL]) |=> !flags[EV_FALL];
    endproperty
    a_fall_needs_enable: assert property (p_fall_needs_enable)
        else $error("fall flag set while comparator disabled");

    // irq is a registered image of the flags, never ahead of them
    property p_irq_quiet;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !(|flags) |-> !o_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt high with no flag set");

    property p_wait_idle;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !req |=> o_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest low without a request");
endmodule
`default_nettype wire

// *** verification/tb_cefl_top.sv ***
// register-level bench for the comparator edge-flag block
`timescale 1ns/1ps
`default_nettype none
module tb_cefl_top
    import cefl_pkg::*;
;
    logic              i_core_clk;
    logic              i_rstn;
    logic [ADDR_W-1:0] i_address;
    logic              i_read;
    logic              i_write;
    logic [3:0]        i_byteenable;
    logic [DATA_W-1:0] i_writedata;
    logic [DATA_W-1:0] o_readdata;
    logic              o_waitrequest;
    logic              i_cmp_out;
    logic              o_cmp_enable;
    logic [HYST_W-1:0] o_cmp_pos_hyst_sel;
    logic [HYST_W-1:0] o_cmp_neg_hyst_sel;
    logic              o_irq;
    int                err_total;
    int                comparisons;
    logic [31:0]       q;

    cefl_top i_dut (
        .i_core_clk         (i_core_clk),
        .i_rstn             (i_rstn),
        .i_address          (i_address),
        .i_read             (i_read),
        .i_write            (i_write),
        .i_byteenable       (i_byteenable),
        .i_writedata        (i_writedata),
        .o_readdata         (o_readdata),
        .o_waitrequest      (o_waitrequest),
        .i_cmp_out          (i_cmp_out),
        .o_cmp_enable       (o_cmp_enable),
        .o_cmp_pos_hyst_sel (o_cmp_pos_hyst_sel),
        .o_cmp_neg_hyst_sel (o_cmp_neg_hyst_sel),
        .o_irq              (o_irq)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one avalon transfer; caller stands just after a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        i_address    <= a;
        i_write      <= wr;
        i_read       <= ~wr;
        i_writedata  <= d;
        i_byteenable <= be;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        rd = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            $display("FAIL waitrequest expected 0 seen stuck");
        end
        // idle edge so the next request is not driven in the same step
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(what, q, exp);
    endtask

    // long enough for synchroniser, flag and irq to settle
    task automatic set_cmp(input logic v);
        i_cmp_out <= v;
        repeat (8) @(posedge i_core_clk);
    endtask

    initial begin
        repeat (5000) @(posedge i_core_clk);
        err_total++;
        $display("FAIL watchdog expected finish seen hang");
        test_done();
    end

    initial begin
        err_total = 0;
        comparisons = 0;
        i_rstn = 1'b0;
        i_address = 4'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_byteenable = 4'h0;
        i_writedata = 32'h0;
        i_cmp_out = 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_core_clk);

        check("enable", o_cmp_enable, 32'h0);
        check("pos_hyst", o_cmp_pos_hyst_sel, 32'h0);
        check("neg_hyst", o_cmp_neg_hyst_sel, 32'h0);
        check("irq", o_irq, 32'h0);
        check("waitrequest", o_waitrequest, 32'h1);
        rd("ctrl", OFS_CTRL, 32'h0);
        rd("status", OFS_STATUS, 32'h0);
        rd("clear", OFS_CLEAR, 32'h0);
        rd("irq_en", OFS_IRQ_EN, 32'h0);
        rd("unmapped", 4'h2, 32'h0);
        $display("test reset done");

        // every hysteresis code on both fields, result bit not writable
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL, 32'hc0 | (c << 2) | (3 - c));
            check("pos_hyst", o_cmp_pos_hyst_sel, c);
            check("neg_hyst", o_cmp_neg_hyst_sel, 3 - c);
            check("enable", o_cmp_enable, 32'h1);
            rd("ctrl", OFS_CTRL, 32'h80 | (c << 2) | (3 - c));
        end
        $display("test hysteresis done");

        wr(OFS_CTRL, 32'hb0);
        wr(OFS_IRQ_EN, 32'h3);
        set_cmp(1'b1);
        rd("ctrl", OFS_CTRL, 32'he0);
        rd("status", OFS_STATUS, 32'h1);
        check("irq", o_irq, 32'h1);
        set_cmp(1'b0);
        rd("ctrl", OFS_CTRL, 32'hb0);
        rd("status", OFS_STATUS, 32'h3);
        wr(OFS_CLEAR, 32'h1);
        rd("status", OFS_STATUS, 32'h2);
        check("irq", o_irq, 32'h1);
        wr(OFS_CTRL, 32'ha0);
        rd("status", OFS_STATUS, 32'h0);
        check("irq", o_irq, 32'h0);
        $display("test edges done");

        wr(OFS_IRQ_EN, 32'h2);
        set_cmp(1'b1);
        rd("status", OFS_STATUS, 32'h1);
        check("irq", o_irq, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        // irq is registered from the old enable, so it follows one edge late
        @(posedge i_core_clk);
        check("irq", o_irq, 32'h1);
        wr(OFS_STATUS, 32'h0);
        bus(1'b1, OFS_CLEAR, 32'h3, 4'h0, q);
        rd("status", OFS_STATUS, 32'h1);
        wr(OFS_CLEAR, 32'h3);
        rd("status", OFS_STATUS, 32'h0);
        check("irq", o_irq, 32'h0);
        $display("test mask done");

        // no flags while disabled, none on enabling with input high
        wr(OFS_CTRL, 32'h30);
        check("enable", o_cmp_enable, 32'h0);
        set_cmp(1'b0);
        set_cmp(1'b1);
        rd("ctrl", OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h80);
        repeat (8) @(posedge i_core_clk);
        rd("status", OFS_STATUS, 32'h0);
        rd("ctrl", OFS_CTRL, 32'hc0);
        $display("test disable done");

        // clear lands on the flag-setting edge at d=3, one edge later at d=4
        for (int d = 3; d < 5; d++) begin
            set_cmp(1'b0);
            wr(OFS_CLEAR, 32'h3);
            i_cmp_out <= 1'b1;
            repeat (d) @(posedge i_core_clk);
            wr(OFS_CLEAR, 32'h1);
            rd("status", OFS_STATUS, (d == 3) ? 32'h1 : 32'h0);
        end
        $display("test set beats clear done");

        // mid-run reset returns every register to its reset value
        wr(OFS_IRQ_EN, 32'h3);
        wr(OFS_CTRL, 32'hbe);
        set_cmp(1'b0);
        check("pos_hyst", o_cmp_pos_hyst_sel, 32'h3);
        check("irq", o_irq, 32'h1);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        check("enable", o_cmp_enable, 32'h0);
        check("pos_hyst", o_cmp_pos_hyst_sel, 32'h0);
        check("neg_hyst", o_cmp_neg_hyst_sel, 32'h0);
        check("irq", o_irq, 32'h0);
        check("waitrequest", o_waitrequest, 32'h1);
        rd("status", OFS_STATUS, 32'h0);
        rd("irq_en", OFS_IRQ_EN, 32'h0);
        $display("test mid reset done");
        test_done();
    end
endmodule
`default_nettype wire
